// File: verilog/led_intensity_pwm_regs.v
// Intensity registers and PWM drive for the ninth, first and second open-drain outputs
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_defines.vh"

module led_intensity_pwm_regs (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst_n,
    // Register port from the serial interface
    input  wire [7:0] regAddr,
    input  wire       regWrite,
    input  wire       regRead,
    input  wire [7:0] regWdata,
    output reg  [7:0] regRdata_q,
    output reg        regRvalid_q,
    // Open-drain sink enables: bit 0 first, bit 1 second, bit 2 ninth output
    output wire [2:0] ledSinkOe,
    // Status
    output reg        oscRunning_q
);

    reg  [7:0] masterNinth_q;
    reg  [7:0] firstPair_q;
    wire [3:0] slot;
    wire [3:0] phase;
    wire [3:0] masterLevel;
    wire [3:0] ninthLevel;
    wire [3:0] firstLevel;
    wire [3:0] secondLevel;
    wire       selMasterNinth;
    wire       selFirstPair;
    wire       oscEnable;

    // Address decode shared by both registers
    function addrHits;
        input [7:0] addr;
        input [7:0] code;
        begin
            addrHits = (addr == code);
        end
    endfunction

    // True when a level field holds the all-off code
    function levelIsZero;
        input [3:0] level;
        begin
            levelIsZero = (level == `LEVEL_ZERO);
        end
    endfunction

    assign selMasterNinth = addrHits(regAddr, `ADDR_MASTER_NINTH);
    assign selFirstPair   = addrHits(regAddr, `ADDR_FIRST_PAIR);
    assign oscEnable      = !levelIsZero(masterLevel);

    assign masterLevel = masterNinth_q[`MASTER_MSB:`MASTER_LSB];
    assign ninthLevel  = masterNinth_q[`NINTH_MSB:`NINTH_LSB];
    assign secondLevel = firstPair_q[`SECOND_MSB:`SECOND_LSB];
    assign firstLevel  = firstPair_q[`FIRST_MSB:`FIRST_LSB];

    // Register writes store the full byte
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            masterNinth_q <= `RST_MASTER_NINTH;
            firstPair_q   <= `RST_FIRST_PAIR;
        end else if (regWrite) begin
            if (selMasterNinth) begin
                masterNinth_q <= regWdata;
            end
            if (selFirstPair) begin
                firstPair_q <= regWdata;
            end
        end
    end

    // Read-back one cycle after the strobe; unmapped addresses return zero
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_q  <= `RST_READ_DATA;
            regRvalid_q <= 1'b0;
        end else begin
            regRvalid_q <= regRead;
            if (regRead) begin
                if (selMasterNinth) begin
                    regRdata_q <= masterNinth_q;
                end else if (selFirstPair) begin
                    regRdata_q <= firstPair_q;
                end else begin
                    regRdata_q <= `RST_READ_DATA;
                end
            end
        end
    end

    // Oscillator runs only while the master level is nonzero
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            oscRunning_q <= 1'b0;
        end else begin
            oscRunning_q <= oscEnable;
        end
    end

    pwm_frame_counter frame (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .oscRun  (oscEnable),
        .slot_q  (slot),
        .phase_q (phase)
    );

    led_duty_output firstOut (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .masterLevel (masterLevel),
        .outputLevel (firstLevel),
        .slot        (slot),
        .phase       (phase),
        .sinkOe_q    (ledSinkOe[0])
    );

    led_duty_output secondOut (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .masterLevel (masterLevel),
        .outputLevel (secondLevel),
        .slot        (slot),
        .phase       (phase),
        .sinkOe_q    (ledSinkOe[1])
    );

    led_duty_output ninthOut (
        .sys_clk     (sys_clk),
        .rst_n       (rst_n),
        .masterLevel (masterLevel),
        .outputLevel (ninthLevel),
        .slot        (slot),
        .phase       (phase),
        .sinkOe_q    (ledSinkOe[2])
    );

endmodule
`default_nettype wire

// File: common/led_pwm_defines.vh
// Register addresses, field positions, reset values and timing counts of the LED intensity block
`ifndef LED_PWM_DEFINES_VH
`define LED_PWM_DEFINES_VH

// Register address codes
`define ADDR_MASTER_NINTH   8'h0e
`define ADDR_FIRST_PAIR     8'h10

// Field positions inside the master and ninth-output register
`define MASTER_MSB          7
`define MASTER_LSB          4
`define NINTH_MSB           3
`define NINTH_LSB           0

// Field positions inside the first pair register
`define SECOND_MSB          7
`define SECOND_LSB          4
`define FIRST_MSB           3
`define FIRST_LSB           0

// Reset values
`define RST_MASTER_NINTH    8'h00
`define RST_FIRST_PAIR      8'h00
`define RST_READ_DATA       8'h00

// Level encodings
`define LEVEL_ZERO          4'h0
`define LEVEL_STATIC        4'hf
`define MASTER_FULL         4'hf

// Frame geometry: sixteen slots per subframe, fifteen master phases
`define SLOT_LAST           4'hf
`define PHASE_LAST          4'he

// Internal oscillator: sys_clk cycles per PWM slot
`define OSC_DIV_LAST        8'h03
`define OSC_DIV_ZERO        8'h00

`endif

// File: verilog/pwm_frame_counter.v
// Internal PWM oscillator and the shared slot and master-phase counter
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_defines.vh"

module pwm_frame_counter (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst_n,
    // Oscillator run control
    input  wire       oscRun,
    // Frame position
    output reg  [3:0] slot_q,
    output reg  [3:0] phase_q
);

    reg [7:0] divCount_q;

    wire tick = (divCount_q == `OSC_DIV_LAST);

    // A stopped oscillator parks the frame at its start
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            divCount_q <= `OSC_DIV_ZERO;
            slot_q     <= `LEVEL_ZERO;
            phase_q    <= `LEVEL_ZERO;
        end else if (!oscRun) begin
            divCount_q <= `OSC_DIV_ZERO;
            slot_q     <= `LEVEL_ZERO;
            phase_q    <= `LEVEL_ZERO;
        end else if (tick) begin
            divCount_q <= `OSC_DIV_ZERO;
            slot_q     <= slot_q + 4'h1;
            if (slot_q == `SLOT_LAST) begin
                if (phase_q == `PHASE_LAST) begin
                    phase_q <= `LEVEL_ZERO;
                end else begin
                    phase_q <= phase_q + 4'h1;
                end
            end
        end else begin
            divCount_q <= divCount_q + 8'h01;
        end
    end

endmodule
`default_nettype wire

// File: verilog/led_duty_output.v
// One open-drain output: combines master and output level into a registered sink enable
`timescale 1ns/1ps
`default_nettype none
`include "led_pwm_defines.vh"

module led_duty_output (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       rst_n,
    // Levels
    input  wire [3:0] masterLevel,
    input  wire [3:0] outputLevel,
    // Frame position
    input  wire [3:0] slot,
    input  wire [3:0] phase,
    // Open-drain sink enable, high while pulling low
    output reg        sinkOe_q
);

    wire masterOn = (phase < masterLevel);

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sinkOe_q <= 1'b0;
        end else if (masterLevel == `LEVEL_ZERO) begin
            sinkOe_q <= 1'b0;
        end else if (outputLevel == `LEVEL_STATIC) begin
            // Static low across the subframe; only the master scale can gate it
            sinkOe_q <= (masterLevel == `MASTER_FULL) | masterOn;
        end else begin
            // Slots 0..level sink: level+1 sixteenths
            sinkOe_q <= masterOn & (slot <= outputLevel);
        end
    end

endmodule
`default_nettype wire

// File: tb/reg_host_model.sv
// Host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module reg_host_model (
    // Clock
    input  wire logic       sys_clk,
    // Register requests
    output var  logic [7:0] regAddr,
    output var  logic       regWrite,
    output var  logic       regRead,
    output var  logic [7:0] regWdata,
    // Read answer
    input  wire logic [7:0] regRdata_q,
    input  wire logic       regRvalid_q
);
    initial begin
        regAddr = 8'h00;
        regWrite = 1'b0;
        regRead = 1'b0;
        regWdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
        regWdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        @(posedge sys_clk);
        d = regRvalid_q ? regRdata_q : 8'hxx;
    endtask
endmodule
`default_nettype wire

// File: tb/led_pwm_checker.sv
// Assertion checker for the LED intensity register block
`timescale 1ns/1ps
`default_nettype none
module led_pwm_checker (
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata_q,
    input wire logic       regRvalid_q,
    // Outputs and status
    input wire logic [2:0] ledSinkOe,
    input wire logic       oscRunning_q
);
    logic [7:0] mn_q;
    logic [7:0] pr_q;
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mn_q <= 8'h00;
            pr_q <= 8'h00;
        end else if (regWrite) begin
            if (regAddr == 8'h0e) mn_q <= regWdata;
            if (regAddr == 8'h10) pr_q <= regWdata;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    a_read_answer: assert property (regRead |=> regRvalid_q) else $error("no answer");
    a_no_answer: assert property (!regRead |=> !regRvalid_q) else $error("stray answer");
    a_rdata_hold: assert property (!regRead |=> $stable(regRdata_q)) else $error("data moved");
    a_read_back: assert property (regRead |=> regRdata_q == ($past(regAddr) == 8'h0e ?
        $past(mn_q) : $past(regAddr) == 8'h10 ? $past(pr_q) : 8'h00)) else $error("bad read");
    a_osc_stop: assert property (mn_q[7:4] == 4'h0 [*2] |-> !oscRunning_q) else $error("osc");
    a_osc_run: assert property (mn_q[7:4] != 4'h0 [*2] |-> oscRunning_q) else $error("osc");
    a_master_dark: assert property (mn_q[7:4] == 4'h0 [*4] |-> !(|ledSinkOe)) else $error("lit");
    a_ninth_static: assert property (mn_q == 8'hff [*4] |-> ledSinkOe[2]) else $error("ninth");
    a_first_static: assert property ({mn_q[7:4], pr_q[3:0]} == 8'hff [*4] |-> ledSinkOe[0])
        else $error("first");
    cover property (regRead && regAddr == 8'h10);
    cover property (mn_q == 8'hff [*4]);
    cover property ($rose(oscRunning_q));
endmodule
bind led_intensity_pwm_regs led_pwm_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
    .regRdata_q(regRdata_q), .regRvalid_q(regRvalid_q), .ledSinkOe(ledSinkOe),
    .oscRunning_q(oscRunning_q));
`default_nettype wire

// File: tb/led_intensity_pwm_regs_tb.sv
// Self-checking testbench for the LED intensity register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    numChecks++; \
    if ((g) !== (e)) begin \
        badCount++; \
        $display("mismatch %0t: got %0h want %0h", $time, (g), (e)); \
    end \
end
module led_intensity_pwm_regs_tb;
    logic       sys_clk = 1'b0;
    logic       rst_n = 1'b0;
    wire  [7:0] regAddr;
    wire        regWrite;
    wire        regRead;
    wire  [7:0] regWdata;
    wire  [7:0] regRdata_q;
    wire        regRvalid_q;
    wire  [2:0] ledSinkOe;
    wire        oscRunning;
    int         badCount = 0;
    int         numChecks = 0;
    int         cycles = 0;
    always #10 sys_clk = ~sys_clk;
    led_intensity_pwm_regs u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata), .regRdata_q(regRdata_q),
        .regRvalid_q(regRvalid_q), .ledSinkOe(ledSinkOe), .oscRunning_q(oscRunning));
    reg_host_model u_host (.sys_clk(sys_clk), .regAddr(regAddr), .regWrite(regWrite),
        .regRead(regRead), .regWdata(regWdata), .regRdata_q(regRdata_q), .regRvalid_q(regRvalid_q));
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 8000) begin
            badCount++;
            printVerdict();
        end
    end
    task automatic test_regs;
        logic [7:0] d;
        u_host.wr(8'h0e, 8'h5a);
        u_host.rd(8'h0e, d);
        `CHK(d, 8'h5a)
        u_host.wr(8'h10, 8'hc3);
        u_host.wr(8'h11, 8'hff);
        u_host.rd(8'h10, d);
        `CHK(d, 8'hc3)
        u_host.rd(8'h11, d);
        `CHK(d, 8'h00)
        $display("test_regs done");
    endtask
    task automatic run_case(input logic [7:0] mn, pr, input int e0, e1, e2);
        int c[3];
        u_host.wr(8'h10, pr);
        u_host.wr(8'h0e, mn);
        repeat (8) @(posedge sys_clk);
        c = '{0, 0, 0};
        repeat (960) begin
            @(posedge sys_clk);
            for (int i = 0; i < 3; i++) begin
                // An unknown enable spoils the count so it cannot pass
                c[i] += (ledSinkOe[i] === 1'b1) ? 1 : ((ledSinkOe[i] === 1'b0) ? 0 : 1000);
            end
        end
        `CHK(c[0], e0)
        `CHK(c[1], e1)
        `CHK(c[2], e2)
        `CHK(oscRunning, mn[7:4] != 4'h0)
    endtask
    task automatic test_duty;
        run_case(8'hf3, 8'he0, 60, 900, 240);
        run_case(8'hff, 8'h0f, 960, 60, 960);
        run_case(8'h5f, 8'h0f, 320, 20, 320);
        run_case(8'h0f, 8'hff, 0, 0, 0);
        $display("test_duty done");
    endtask
    initial begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        test_regs();
        test_duty();
        printVerdict();
    end
endmodule
`default_nettype wire
